// file: hdl/uxf_flow.sv
`timescale 1ns/1ps
`default_nettype none

// small synchronous FIFO, flip-flop storage indexed by pointer
module uxf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk_i,   // system clock
  input  wire logic             rst_n_i,     // async reset, active low
  input  wire logic             in_valid_i,  // write request
  output logic                  in_ready_o,  // space available
  input  wire logic [WIDTH-1:0] in_data_i,   // write data
  output logic                  out_valid_o, // data available
  input  wire logic             out_ready_i, // consumer takes word
  output logic      [WIDTH-1:0] out_data_o   // head word
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push;
  wire              pop;

  // a full count of DEPTH stops the writer, empty stops the reader
  assign in_ready_o  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointers wrap naturally since DEPTH is a power of two
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + PW'(1);
      if (pop)  rd_ptr_reg <= rd_ptr_reg + PW'(1);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage has no reset; contents only matter once valid
  always_ff @(posedge sys_clk_i) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data_i;
  end

endmodule : uxf_fifo

// Summary of operation
// R1 - software enables receive control with nonzero pattern
// R2 - pattern selects pair one, two, or both
// R3 - xoff stops new starts, current char finishes
// R4 - xon resumes transmit FIFO draining
// R5 - status bit zero: 0 xon, 1 xoff
// R6 - enabled xoff interrupt, cleared by read or xon
// R7 - line empty bits ignore flow suspension
// R8 - parity-errored flow characters still act
// R9 - equal xon/xoff in single mode means xon
// R10 - repeated first char then second completes
// R11 - lone second character stored as data
// R12 - unfollowed first character stored as data
// R13 - alternating first characters change nothing
// R14 - fully equal pairs recognise only xon
// R15 - xon any: any char resumes from xoff
// R16 - xon any single: xoff in xoff resumes
// R17 - xon any pair: lone second xon stored
// R18 - xon any pair: xoff pair toggles status; the code ends in xoff only if the pair began in xoff, else it stays xon
// R19 - single xoff1 mode: xoff2 is special
// R20 - unpreceded second xoff flagged special
// R21 - no resend: xoff sent only once
// R22 - resend xoff every 1/4/8/16 characters
// R23 - software remaps bit two then sets it
// R24 - software picks interval near full FIFO
// R25 - characters programmable, compared after framing
module uxf_flow
  import uxf_pkg::*;
(
  input  wire logic              sys_clk_i,      // 125 MHz system clock
  input  wire logic              rst_n_i,        // async reset, active low
  input  wire logic [3:0]        enhanced_feature_reg_i, // flow options
  input  wire uxf_chars_s        flow_chars_i,   // xon1/xon2/xoff1/xoff2
  input  wire logic              interrupt_enable_reg_i, // xoff irq enable
  input  wire logic              isr_read_i,     // status read strobe
  input  wire logic              mcr_wr_i,       // modem control write
  input  wire logic [7:0]        mcr_data_i,     // modem control data
  input  wire logic              special_en_i,   // special char detect on
  input  wire logic [1:0]        xoff_resend_ctrl_i, // resend interval
  input  wire logic              tx_xoff_state_i, // local xoff sent
  input  wire logic              rx_valid_i,     // framed char offered
  output logic                   rx_ready_o,     // char taken
  input  wire logic [CHAR_W-1:0] rx_char_i,      // framed character
  output logic                   data_valid_o,   // stored data ready
  input  wire logic              data_ready_i,   // consumer takes data
  output logic      [CHAR_W-1:0] data_o,         // stored character
  input  wire logic              tx_fifo_empty_i, // transmit FIFO empty
  input  wire logic              tx_fifo_full_i, // transmit FIFO full
  input  wire logic              tx_busy_i,      // shifter active
  output logic                   tx_start_o,     // start next character
  output logic                   flow_status_o,  // 0 xon, 1 xoff
  output uxf_line_s              line_status_o,  // empty bits
  output logic                   irq_o,          // xoff interrupt
  output logic      [5:0]        interrupt_status_reg_o, // irq code
  output logic                   special_o,      // special char pulse
  output logic                   xoff_resend_o   // resend xoff pulse
);

  // state
  logic                    status_reg;
  logic                    status_next;
  uxf_pend_e               pend_reg;
  uxf_pend_e               pend_next;
  logic [CHAR_W-1:0]       pend_char_reg;
  logic                    from_xoff_reg;
  logic                    from_xoff_next;
  logic                    irq_reg;
  logic                    special_reg;
  logic                    special_next;
  logic                    resend_reg;
  logic                    resend_en_reg;
  logic                    xon_any_reg;
  logic [RESEND_CNT_W-1:0] resend_cnt_reg;
  logic                    store;
  logic                    xoff_evt;

  // decode of modes and character matches
  wire [1:0] rx_mode   = enhanced_feature_reg_i[EFR_RX_LSB +: 2];
  wire       rx_on     = (rx_mode != EFR_RX_OFF);
  wire       two_char  = (rx_mode == EFR_RX_BOTH);
  wire       pair1     = (rx_mode == EFR_RX_PAIR1);
  wire [CHAR_W-1:0] s_xon  = pair1 ? flow_chars_i.xon1 : flow_chars_i.xon2;
  wire [CHAR_W-1:0] s_xoff = pair1 ? flow_chars_i.xoff1 : flow_chars_i.xoff2;
  // parity status never enters the match, so errored chars still act
  wire       s_on      = (rx_char_i == s_xon);                   // see R8
  wire       s_off     = (rx_char_i == s_xoff) && (s_xon != s_xoff); // see R9
  // equal pairs leave only xon recognition
  wire       off_ok    = !((flow_chars_i.xon1 == flow_chars_i.xoff1) &&
                           (flow_chars_i.xon2 == flow_chars_i.xoff2)); // see R14
  wire       m_on1     = (rx_char_i == flow_chars_i.xon1);        // see R25
  wire       m_on2     = (rx_char_i == flow_chars_i.xon2);
  wire       m_off1    = (rx_char_i == flow_chars_i.xoff1) && off_ok;
  wire       m_off2    = (rx_char_i == flow_chars_i.xoff2) && off_ok;
  wire       in_xoff   = (status_reg == FLOW_XOFF);

  // a pending first char that is not continued is pushed out first;
  // the new char waits a cycle so the two land in order
  wire       cont_on   = m_on2 | m_on1 | m_off1;
  wire       cont_off  = m_off2 | m_off1 | m_on1;
  wire       flush     = rx_on && two_char && rx_valid_i &&
                         ((pend_reg == PEND_ON  && !cont_on) ||
                          (pend_reg == PEND_OFF && !cont_off)); // see R12
  wire       fifo_rdy;
  wire       take      = rx_valid_i && fifo_rdy && !flush;
  wire       push      = flush || (take && store);
  wire [CHAR_W-1:0] push_data = flush ? pend_char_reg : rx_char_i;

  assign rx_ready_o = fifo_rdy && !flush;

  // character classification and next status
  always_comb begin
    status_next    = status_reg;
    pend_next      = pend_reg;
    from_xoff_next = from_xoff_reg;
    store          = 1'b0;
    xoff_evt       = 1'b0;
    special_next   = 1'b0;
    if (!rx_on) begin
      // no receive matching at all
      status_next = FLOW_XON;                              // see R2
      pend_next   = PEND_NONE;
      store       = 1'b1;
    end else if (flush) begin
      // a full buffer keeps the pending char until it can be pushed
      pend_next = fifo_rdy ? PEND_NONE : pend_reg;
    end else if (take && !two_char) begin
      if (s_on) begin
        status_next = FLOW_XON;                            // see R4
      end else if (s_off) begin
        if (xon_any_reg && in_xoff) begin
          status_next = FLOW_XON;                          // see R16
        end else begin
          status_next = FLOW_XOFF;                         // see R3
          xoff_evt    = 1'b1;
        end
      end else begin
        store = 1'b1;
        if (xon_any_reg) status_next = FLOW_XON;           // see R15
        special_next = special_en_i && pair1 &&
                       (rx_char_i == flow_chars_i.xoff2);  // see R19
      end
    end else if (take) begin
      unique case (pend_reg)
        PEND_NONE: begin
          if (m_on1) begin
            pend_next = PEND_ON;
            if (xon_any_reg) status_next = FLOW_XON;       // see R17
          end else if (m_off1) begin
            pend_next      = PEND_OFF;
            from_xoff_next = in_xoff;
            if (xon_any_reg) status_next = FLOW_XON;       // see R18
          end else begin
            store = 1'b1;                                  // see R11
            if (xon_any_reg) status_next = FLOW_XON;       // see R17
            special_next = special_en_i && m_off2;         // see R20
          end
        end
        PEND_ON: begin
          if (m_on2) begin
            status_next = FLOW_XON;                        // see R4
            pend_next   = PEND_NONE;
          end else if (m_off1) begin
            pend_next      = PEND_OFF;                     // see R13
            from_xoff_next = in_xoff;
          end
          // a repeated xon1 simply replaces the earlier one; see R10
        end
        PEND_OFF: begin
          if (m_off2) begin
            pend_next = PEND_NONE;
            if (!xon_any_reg || from_xoff_reg) begin
              status_next = FLOW_XOFF;                     // see R18
              xoff_evt    = 1'b1;                          // see R10
            end
          end else if (m_on1) begin
            pend_next = PEND_ON;                           // see R13
          end
        end
      endcase
    end
  end

  // flow state registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg    <= FLOW_XON;
      pend_reg      <= PEND_NONE;
      pend_char_reg <= '0;
      from_xoff_reg <= 1'b0;
      special_reg   <= 1'b0;
    end else begin
      status_reg    <= status_next;
      pend_reg      <= pend_next;
      from_xoff_reg <= from_xoff_next;
      special_reg   <= special_next && take;
      if (take) pend_char_reg <= rx_char_i;
    end
  end

  // irq: set wins over clear; any return to xon removes it
  wire irq_set = xoff_evt && interrupt_enable_reg_i;       // see R6
  wire irq_clr = isr_read_i || (in_xoff && status_next == FLOW_XON);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_set || (irq_reg && !irq_clr);         // see R6
    end
  end

  // modem control shadow; bit two only counts when remap bit is set
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xon_any_reg   <= 1'b0;
      resend_en_reg <= 1'b0;
    end else if (mcr_wr_i) begin
      xon_any_reg <= mcr_data_i[MCR_XONANY_BIT];           // see R15
      if (mcr_data_i[MCR_REMAP_BIT]) begin
        resend_en_reg <= mcr_data_i[MCR_RESEND_BIT];       // see R23
      end
    end
  end

  // chosen interval in characters
  function automatic logic [RESEND_CNT_W-1:0] resend_n(
    input logic [1:0] sel
  );
    unique case (sel)
      RESEND_SEL_1: resend_n = RESEND_N_1;
      RESEND_SEL_4: resend_n = RESEND_N_4;
      RESEND_SEL_8: resend_n = RESEND_N_8;
      default:      resend_n = RESEND_N_16;
    endcase
  endfunction : resend_n

  // count stored chars while the local side sits in xoff
  wire       count_evt = take && store && tx_xoff_state_i;
  wire [RESEND_CNT_W-1:0] cnt_inc = resend_cnt_reg + RESEND_CNT_W'(1);
  wire       resend_hit = count_evt && resend_en_reg &&
                          (cnt_inc == resend_n(xoff_resend_ctrl_i)); // see R22

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resend_cnt_reg <= '0;
      resend_reg     <= 1'b0;
    end else begin
      // without resend the counter idles and nothing is re-sent
      resend_reg <= resend_hit;                            // see R21
      if (!tx_xoff_state_i || !resend_en_reg || resend_hit) begin
        resend_cnt_reg <= '0;
      end else if (count_evt) begin
        resend_cnt_reg <= cnt_inc;
      end
    end
  end

  // receive data buffer; a full buffer stalls the receiver
  uxf_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (push_data),
    .out_valid_o (data_valid_o),
    .out_ready_i (data_ready_i),
    .out_data_o  (data_o)
  );

  // transmit gating: only new starts are held, the shifter finishes
  assign tx_start_o = !tx_fifo_empty_i && !tx_busy_i && !in_xoff; // see R3
  // line bits look at FIFO and shifter state only, never at suspension
  assign line_status_o.thr_empty = !tx_fifo_full_i;        // see R7
  assign line_status_o.tx_empty  = tx_fifo_empty_i && !tx_busy_i; // see R7

  // status outputs
  assign flow_status_o          = status_reg;              // see R5
  assign irq_o                  = irq_reg;
  assign interrupt_status_reg_o = irq_reg ? ISR_XOFF_CODE : ISR_NONE_CODE;
  assign special_o              = special_reg;
  assign xoff_resend_o          = resend_reg;

endmodule : uxf_flow

`default_nettype wire

// file: hdl/uxf_pkg.sv
`default_nettype none

package uxf_pkg;

  // character width and receive buffer shape
  localparam int unsigned CHAR_W     = 8;
  localparam int unsigned FIFO_DEPTH = 16;

  // receive flow control field of enhanced_feature_reg
  localparam int unsigned EFR_RX_LSB   = 0;
  localparam logic [1:0]  EFR_RX_OFF   = 2'h0;
  localparam logic [1:0]  EFR_RX_PAIR2 = 2'h1;
  localparam logic [1:0]  EFR_RX_PAIR1 = 2'h2;
  localparam logic [1:0]  EFR_RX_BOTH  = 2'h3;

  // modem_control_reg bit positions
  localparam int unsigned MCR_REMAP_BIT  = 6;
  localparam int unsigned MCR_XONANY_BIT = 5;
  localparam int unsigned MCR_RESEND_BIT = 2;

  // interrupt enable bit and the code shown in interrupt_status_reg
  localparam int unsigned IER_XOFF_BIT  = 5;
  localparam logic [5:0]  ISR_NONE_CODE = 6'h01;
  localparam logic [5:0]  ISR_XOFF_CODE = 6'h10;

  // flow status encoding of flow_status_reg bit zero
  localparam logic FLOW_XON  = 1'b0;
  localparam logic FLOW_XOFF = 1'b1;

  // xoff_resend_ctrl intervals, in received characters
  localparam int unsigned RESEND_CNT_W = 5;
  localparam logic [1:0]  RESEND_SEL_1  = 2'h0;
  localparam logic [1:0]  RESEND_SEL_4  = 2'h1;
  localparam logic [1:0]  RESEND_SEL_8  = 2'h2;
  localparam logic [RESEND_CNT_W-1:0] RESEND_N_1  = 5'h01;
  localparam logic [RESEND_CNT_W-1:0] RESEND_N_4  = 5'h04;
  localparam logic [RESEND_CNT_W-1:0] RESEND_N_8  = 5'h08;
  localparam logic [RESEND_CNT_W-1:0] RESEND_N_16 = 5'h10;

  // pending first-character state in two-character mode
  typedef enum logic [1:0] {
    PEND_NONE,
    PEND_ON,
    PEND_OFF
  } uxf_pend_e;

  // the four programmable flow control characters
  typedef struct packed {
    logic [CHAR_W-1:0] xon1;
    logic [CHAR_W-1:0] xon2;
    logic [CHAR_W-1:0] xoff1;
    logic [CHAR_W-1:0] xoff2;
  } uxf_chars_s;

  // line status bits that follow the transmit FIFO and shifter only
  typedef struct packed {
    logic tx_empty;
    logic thr_empty;
  } uxf_line_s;

endpackage : uxf_pkg

`default_nettype wire

// file: tb/uxf_flow_props.sv
`timescale 1ns/1ps
`default_nettype none

module uxf_flow_props
  import uxf_pkg::*;
(
  input wire logic       sys_clk_i,              // clock
  input wire logic       rst_n_i,                // reset, active low
  input wire logic [3:0] enhanced_feature_reg_i, // flow options
  input wire logic       interrupt_enable_reg_i, // irq enable
  input wire logic       isr_read_i,             // status read
  input wire logic       rx_valid_i,             // char offered
  input wire logic       rx_ready_o,             // char taken
  input wire logic       tx_fifo_empty_i,        // tx fifo empty
  input wire logic       tx_fifo_full_i,         // tx fifo full
  input wire logic       tx_busy_i,              // shifter busy
  input wire logic       tx_xoff_state_i,        // local xoff sent
  input wire logic       tx_start_o,             // start next char
  input wire logic       flow_status_o,          // flow status
  input wire uxf_line_s  line_status_o,          // empty bits
  input wire logic       irq_o,                  // xoff irq
  input wire logic [5:0] interrupt_status_reg_o, // irq code
  input wire logic       special_o,              // special pulse
  input wire logic       xoff_resend_o           // resend pulse
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // status, start gating and interrupt relations
  chk_xoff_no_start: assert property (
    flow_status_o |-> !tx_start_o) else $error("start while held");
  chk_xon_starts: assert property (
    !flow_status_o && !tx_busy_i && !tx_fifo_empty_i |-> tx_start_o)
    else $error("no start while free");
  chk_status_cause: assert property (
    $changed(flow_status_o) |-> $past(rx_valid_i && rx_ready_o) ||
    $past(enhanced_feature_reg_i[1:0]) == EFR_RX_OFF)
    else $error("status moved without a char");
  chk_off_is_xon: assert property (
    (enhanced_feature_reg_i[1:0] == EFR_RX_OFF) [*2] |->
    flow_status_o == FLOW_XON) else $error("flow off yet held");
  chk_irq_code: assert property (
    interrupt_status_reg_o == (irq_o ? ISR_XOFF_CODE : ISR_NONE_CODE))
    else $error("bad irq code");
  chk_irq_cause: assert property (
    $rose(irq_o) |-> $past(interrupt_enable_reg_i && rx_valid_i &&
    rx_ready_o)) else $error("irq without char");
  chk_irq_read: assert property (
    isr_read_i && !(rx_valid_i && rx_ready_o) |=> !irq_o)
    else $error("irq kept after read");
  // empty bits follow the transmitter only, never flow state
  chk_line_free: assert property (
    $changed(line_status_o) |-> $changed(tx_fifo_full_i) ||
    $changed(tx_fifo_empty_i) || $changed(tx_busy_i))
    else $error("line bits moved by flow");
  chk_resend_cause: assert property (
    xoff_resend_o |-> $past(tx_xoff_state_i))
    else $error("resend outside xoff");
  chk_special_cause: assert property (
    special_o |-> $past(rx_valid_i && rx_ready_o))
    else $error("special without char");

  cover property ($rose(flow_status_o));
  cover property ($rose(irq_o));
  cover property (xoff_resend_o);
  cover property (special_o);
endmodule : uxf_flow_props

bind uxf_flow uxf_flow_props u_props (.*);

`default_nettype wire

// file: tb/uxf_peer.sv
`timescale 1ns/1ps
`default_nettype none

// remote sender: offers framed characters back to back
module uxf_peer
  import uxf_pkg::*;
(
  input  wire logic              sys_clk_i,  // bench clock
  input  wire logic              rx_ready_i, // block takes char
  output logic                   rx_valid_o, // char offered
  output logic      [CHAR_W-1:0] rx_char_o   // framed char
);
  initial begin
    rx_valid_o = 1'b0;
    rx_char_o  = 8'h00;
  end

  // ready is read 1 ns after the falling edge, so the hand-off never races the rising edge
  task automatic send_q(input logic [CHAR_W-1:0] q[$]);
    int   n;
    logic ok;
    foreach (q[i]) begin
      rx_valid_o = 1'b1;
      rx_char_o  = q[i];
      n = 0;
      do begin
        #1 ok = rx_ready_i;
        @(negedge sys_clk_i);
        n++;
      end while (!ok && n < 64);
    end
    rx_valid_o = 1'b0;
    rx_char_o  = ~rx_char_o; // released line shows no stale value
    @(negedge sys_clk_i); // an edge passes before the next call
  endtask : send_q
endmodule : uxf_peer

`default_nettype wire

// file: tb/uxf_flow_bench.sv
`timescale 1ns/1ps
`default_nettype none

module uxf_flow_bench;
  import uxf_pkg::*;
  localparam logic [7:0] ON1 = 8'h11;
  localparam logic [7:0] ON2 = 8'h12;
  localparam logic [7:0] OF1 = 8'h13;
  localparam logic [7:0] OF2 = 8'h14;
  logic       clk, rst_n, irq_en, isr_rd, mcr_wr, spec_en, xoff_st;
  logic       rx_valid, rx_ready, data_valid, data_ready, tx_empty;
  logic       tx_full, tx_busy, tx_start, status, irq, special, resend;
  logic       stall, st;
  logic [3:0] enhanced_feature_reg;
  logic [7:0] mcr_d, rx_char, data, c;
  logic [1:0] rsel;
  logic [5:0] interrupt_status_reg;
  uxf_chars_s chars;
  uxf_line_s  line;
  logic [7:0] exp_q[$];
  logic [31:0] seed, dseed;
  int n_errors, check_count, n_resend, n_special, cyc, k;

  uxf_flow dut (.sys_clk_i(clk), .rst_n_i(rst_n),
    .enhanced_feature_reg_i(enhanced_feature_reg), .flow_chars_i(chars),
    .interrupt_enable_reg_i(irq_en), .isr_read_i(isr_rd),
    .mcr_wr_i(mcr_wr), .mcr_data_i(mcr_d), .special_en_i(spec_en),
    .xoff_resend_ctrl_i(rsel), .tx_xoff_state_i(xoff_st),
    .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_char_i(rx_char),
    .data_valid_o(data_valid), .data_ready_i(data_ready), .data_o(data),
    .tx_fifo_empty_i(tx_empty), .tx_fifo_full_i(tx_full),
    .tx_busy_i(tx_busy), .tx_start_o(tx_start), .flow_status_o(status),
    .line_status_o(line), .irq_o(irq), .interrupt_status_reg_o(interrupt_status_reg),
    .special_o(special), .xoff_resend_o(resend));
  uxf_peer u_peer (.sys_clk_i(clk), .rx_ready_i(rx_ready),
    .rx_valid_o(rx_valid), .rx_char_o(rx_char));

  always #4 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // expected interval for each resend code
  function automatic int nof(input logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : (s == 2'h2) ? 8 : 16;
  endfunction : nof
  // single-char pair one: xon frees, xoff holds, data leaves status
  function automatic logic nst(input logic s, input logic [7:0] ch);
    return (ch == ON1) ? FLOW_XON : (ch == OF1) ? FLOW_XOFF : s;
  endfunction : nst

  task check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task modem_control_reg(input logic [7:0] d);
    mcr_d  = d;
    mcr_wr = 1'b1;
    tick(1);
    mcr_wr = 1'b0;
    tick(1);
  endtask : modem_control_reg
  task drain;
    k = 0;
    while (exp_q.size() != 0 && k < 500) begin
      tick(1);
      k++;
    end
    check(8'(exp_q.size()), 8'h00);
  endtask : drain
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // consumer stalls at random; popped words must match in order
  always @(negedge clk) begin
    dseed = xs(dseed);
    data_ready = !stall && dseed[1:0] != 2'h0;
    n_resend += int'(resend);
    n_special += int'(special);
    cyc++;
    #1;
    if (rst_n && data_ready && data_valid)
      check(data, exp_q.size() ? exp_q.pop_front() : ~data);
    // ceiling far above the few hundred cycles the scenarios need
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    clk = 1'b0; rst_n = 1'b0; irq_en = 1'b1; isr_rd = 1'b0;
    mcr_wr = 1'b0; mcr_d = 8'h00; spec_en = 1'b0; xoff_st = 1'b0;
    tx_empty = 1'b0; tx_full = 1'b0; tx_busy = 1'b0; stall = 1'b0;
    enhanced_feature_reg = 4'h0; rsel = 2'h0; chars = {ON1, ON2, OF1, OF2};
    seed = 32'h000041D1; dseed = seed; st = FLOW_XON;
    tick(10);
    rst_n = 1'b1;
    enhanced_feature_reg = 4'h2;
    tick(1);
    u_peer.send_q('{OF1});
    check(status, FLOW_XOFF);
    check(irq, 1'b1);
    check(interrupt_status_reg, ISR_XOFF_CODE);
    check(tx_start, 1'b0);
    check(line.thr_empty, 1'b1);
    check(line.tx_empty, 1'b0);
    isr_rd = 1'b1;
    tick(1);
    isr_rd = 1'b0;
    check(irq, 1'b0);
    check(interrupt_status_reg, ISR_NONE_CODE);
    u_peer.send_q('{ON1});
    check(tx_start, 1'b1);
    enhanced_feature_reg = 4'h1;
    u_peer.send_q('{OF2});
    check(status, FLOW_XOFF);
    exp_q.push_back(OF1);
    u_peer.send_q('{ON2, OF1});
    check(status, FLOW_XON);
    enhanced_feature_reg = 4'h2;
    // random mix of flow and data chars with the shifter busy at random
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      c = (seed[1:0] == 2'h0) ? ON1 : (seed[1:0] == 2'h1) ? OF1 :
          {2'b01, seed[13:8]};
      tx_busy = seed[4];
      st = nst(st, c);
      if (c != ON1 && c != OF1) exp_q.push_back(c);
      u_peer.send_q('{c});
      check(status, st);
      check(tx_start, st == FLOW_XON && !tx_busy);
    end
    tx_busy = 1'b0;
    u_peer.send_q('{OF1}); // start held so the xon match is visible
    chars.xoff1 = ON1;
    u_peer.send_q('{ON1, ON1});
    check(status, FLOW_XON);
    chars.xoff1 = OF1;
    enhanced_feature_reg = 4'h3;
    spec_en = 1'b1;
    u_peer.send_q('{OF1, OF1, OF2});
    check(status, FLOW_XOFF);
    u_peer.send_q('{ON1, OF1, ON1, OF1});
    check(status, FLOW_XOFF);
    u_peer.send_q('{ON1, ON2});
    check(status, FLOW_XON);
    k = n_special;
    exp_q.push_back(OF2);
    u_peer.send_q('{OF2});
    tick(1);
    check(8'(n_special - k), 8'h01);
    exp_q.push_back(ON1);
    exp_q.push_back(8'h41);
    u_peer.send_q('{ON1, 8'h41});
    enhanced_feature_reg = 4'h2;
    modem_control_reg(8'h20);
    exp_q.push_back(8'h42);
    u_peer.send_q('{OF1, 8'h42});
    check(status, FLOW_XON);
    u_peer.send_q('{OF1, OF1});
    check(status, FLOW_XON);
    enhanced_feature_reg = 4'h3;
    modem_control_reg(8'h00);
    u_peer.send_q('{OF1, OF2});
    modem_control_reg(8'h20);
    u_peer.send_q('{OF1, OF2});
    check(status, FLOW_XOFF);
    exp_q.push_back(ON2);
    u_peer.send_q('{ON2});
    check(status, FLOW_XON);
    enhanced_feature_reg = 4'h0;
    modem_control_reg(8'h40);
    modem_control_reg(8'h44);
    // each interval yields one resend; the longest also fills the buffer
    for (int s = 0; s < 4; s++) begin
      rsel = 2'(s); // single interval first
      xoff_st = 1'b1;
      stall = (s == 3);
      k = n_resend;
      for (int j = 0; j < nof(rsel); j++) begin
        seed = xs(seed);
        exp_q.push_back({2'b01, seed[5:0]});
        u_peer.send_q('{{2'b01, seed[5:0]}});
      end
      tick(2);
      check(8'(n_resend - k), 8'h01);
      if (s == 3) check(rx_ready, 1'b0);
      stall = 1'b0;
      drain();
      check(data_valid, 1'b0);
      xoff_st = 1'b0;
      tick(1);
    end
    modem_control_reg(8'h40);
    xoff_st = 1'b1;
    k = n_resend;
    exp_q.push_back(8'h55);
    exp_q.push_back(8'h66);
    u_peer.send_q('{8'h55, 8'h66});
    tick(2);
    check(8'(n_resend - k), 8'h00);
    drain();
    report_and_stop();
  end
endmodule : uxf_flow_bench

`default_nettype wire
